// ===== rtl/ltd_regs.svh
// register offsets, field positions and reset values for the logical/transport error detect block
`ifndef LTD_REGS_SVH
`define LTD_REGS_SVH
`define LTD_OFF_ERR_DETECT   8'h00
`define LTD_OFF_INT_STATUS   8'h04
`define LTD_OFF_INT_ENABLE   8'h08
`define LTD_OFF_INT_CLEAR    8'h0C
`define LTD_OFF_SRC_CLASS    8'h10
`define LTD_BIT_IO_RSP       31
`define LTD_BIT_MSG_RSP      30
`define LTD_BIT_MSG_FMT      28
`define LTD_BIT_ILL_DEC      27
`define LTD_BIT_MSG_TMO      25
`define LTD_BIT_RSP_TMO      24
`define LTD_BIT_UNSOL        23
`define LTD_BIT_UNSUP        22
`define LTD_BIT_RXQ_SEC      7
`define LTD_BIT_IO_DMA       6
`define LTD_FLAG_MASK        32'hDBC000C0
`define LTD_RST_ERR_DETECT   32'h00000000
`define LTD_RST_INT_ENABLE   3'h0
`define LTD_RST_SRC_CLASS    32'h00000000
`define LTD_INT_ERR          0
`define LTD_INT_CRIT         1
`define LTD_INT_SERV         2
`endif

// ===== rtl/ltd_pkg.sv
// types for the logical/transport error detect block
package ltd_pkg;
    typedef logic [31:0] ltd_word_t;
    typedef logic [7:0]  ltd_addr_t;
    typedef logic [2:0]  ltd_irq_t;
endpackage

// ===== rtl/ltd_error_detect.sv
// logical/transport layer error detect register with three cpu interrupts
//
// Notes on behaviour
// [RULE_01] io error response flag, bit 31, sets when a direct-io request unit gets an error response.
// [RULE_02] message error response flag, bit 30, sets when the message transmit unit gets an error response.
// [RULE_03] message format error flag, bit 28, sets on a bad message payload size or segment.
// [RULE_04] illegal decode flag, bit 27, sets on illegal fields in a response seen by request or transmit units.
// [RULE_05] illegal decode flag, bit 27, also sets on illegal fields in a request seen by memory access or receive unit.
// [RULE_06] message request timeout flag, bit 25, sets when the receive unit times out waiting a message request.
// [RULE_07] response timeout flag, bit 24, sets when a request or transmit unit times out waiting a response.
// [RULE_08] unsolicited response flag, bit 23, sets on a response matching no outstanding request.
// [RULE_09] unsupported transaction flag, bit 22, sets when the memory access unit sees an unadvertised type.
// [RULE_10] receive queue security flag, bit 7, sets when a receive queue access is blocked.
// [RULE_11] inbound io access flag, bit 6, sets when a dma access for the memory access unit is blocked.
// [RULE_12] bits 29, 26, 21 to 8 and 5 to 0 read as zero and ignore writes.
// [RULE_13] a set flag holds until software writes zero to it.
// [RULE_14] an error status interrupt signals run-time errors.
// [RULE_15] a critical error interrupt signals critical error states.
// [RULE_16] a servicing interrupt, separate from the error ones, asks the cpu to attend.
// [RULE_17] writing one to a flag leaves it unchanged.
`timescale 1ns/10ps
`default_nettype none
`include "ltd_regs.svh"
module ltd_error_detect (
    // clock and reset
    input  wire logic            core_clk,
    input  wire logic            rst_n,
    // register port
    input  wire ltd_pkg::ltd_addr_t reg_addr,
    input  wire ltd_pkg::ltd_word_t reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output var  ltd_pkg::ltd_word_t reg_rdata,
    // error events, one-cycle pulses
    input  wire logic            dio_err_rsp,
    input  wire logic            txu_err_rsp,
    input  wire logic            rxu_fmt_err,
    input  wire logic            dio_ill_rsp,
    input  wire logic            txu_ill_rsp,
    input  wire logic            mau_ill_req,
    input  wire logic            rxu_ill_req,
    input  wire logic            rxu_req_tmo,
    input  wire logic            dio_rsp_tmo,
    input  wire logic            txu_rsp_tmo,
    input  wire logic            dio_unsol_rsp,
    input  wire logic            txu_unsol_rsp,
    input  wire logic            mau_unsup,
    input  wire logic            rxu_queue_block,
    input  wire logic            mau_dma_block,
    input  wire logic            critical_event,
    input  wire logic            service_event,
    // interrupts
    output var  logic            irq_error,
    output var  logic            irq_critical,
    output var  logic            irq_service
);
    import ltd_pkg::*;

    ltd_word_t err_q;
    ltd_word_t set_w;
    ltd_word_t class_q;
    ltd_irq_t  ist_q;
    ltd_irq_t  ien_q;
    ltd_irq_t  iset_w;
    logic      wr_err;
    logic      wr_ien;
    logic      wr_icl;
    logic      wr_cls;

    ////////////////////////////////////////////////////////////////////////////
    // event collection
    always_comb begin
        set_w = 32'h00000000;
        set_w[`LTD_BIT_IO_RSP]  = dio_err_rsp; // RULE_01
        set_w[`LTD_BIT_MSG_RSP] = txu_err_rsp; // RULE_02
        set_w[`LTD_BIT_MSG_FMT] = rxu_fmt_err; // RULE_03
        set_w[`LTD_BIT_ILL_DEC] = dio_ill_rsp | txu_ill_rsp | mau_ill_req | rxu_ill_req; // RULE_04 RULE_05
        set_w[`LTD_BIT_MSG_TMO] = rxu_req_tmo; // RULE_06
        set_w[`LTD_BIT_RSP_TMO] = dio_rsp_tmo | txu_rsp_tmo; // RULE_07
        set_w[`LTD_BIT_UNSOL]   = dio_unsol_rsp | txu_unsol_rsp; // RULE_08
        set_w[`LTD_BIT_UNSUP]   = mau_unsup; // RULE_09
        set_w[`LTD_BIT_RXQ_SEC] = rxu_queue_block; // RULE_10
        set_w[`LTD_BIT_IO_DMA]  = mau_dma_block; // RULE_11
    end

    assign wr_err = reg_wr && (reg_addr == `LTD_OFF_ERR_DETECT);
    assign wr_ien = reg_wr && (reg_addr == `LTD_OFF_INT_ENABLE);
    assign wr_icl = reg_wr && (reg_addr == `LTD_OFF_INT_CLEAR);
    assign wr_cls = reg_wr && (reg_addr == `LTD_OFF_SRC_CLASS);

    ////////////////////////////////////////////////////////////////////////////
    // error detect flags: write zero clears, write one keeps, a new event wins
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            err_q <= `LTD_RST_ERR_DETECT;
        end else if (wr_err) begin
            err_q <= ((err_q & reg_wdata) | set_w) & `LTD_FLAG_MASK; // RULE_13 RULE_17 RULE_12
        end else begin
            err_q <= (err_q | set_w) & `LTD_FLAG_MASK; // RULE_13 RULE_12
        end
    end

    // flags marked in the class register count as critical, the rest as error status
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            class_q <= `LTD_RST_SRC_CLASS;
        end else if (wr_cls) begin
            class_q <= reg_wdata & `LTD_FLAG_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status, enable and clear
    always_comb begin
        iset_w = 3'h0;
        iset_w[`LTD_INT_ERR]  = |(set_w & ~class_q); // RULE_14
        iset_w[`LTD_INT_CRIT] = |(set_w & class_q) | critical_event; // RULE_15
        iset_w[`LTD_INT_SERV] = service_event; // RULE_16
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ist_q <= 3'h0;
        end else if (wr_icl) begin
            ist_q <= (ist_q & ~reg_wdata[2:0]) | iset_w;
        end else begin
            ist_q <= ist_q | iset_w;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ien_q <= `LTD_RST_INT_ENABLE;
        end else if (wr_ien) begin
            ien_q <= reg_wdata[2:0];
        end
    end

    // outputs registered, so a level lags status by one cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_error    <= 1'b0;
            irq_critical <= 1'b0;
            irq_service  <= 1'b0;
        end else begin
            irq_error    <= ist_q[`LTD_INT_ERR] & ien_q[`LTD_INT_ERR]; // RULE_14
            irq_critical <= ist_q[`LTD_INT_CRIT] & ien_q[`LTD_INT_CRIT]; // RULE_15
            irq_service  <= ist_q[`LTD_INT_SERV] & ien_q[`LTD_INT_SERV]; // RULE_16
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port; unmapped addresses and the clear register read zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `LTD_OFF_ERR_DETECT: reg_rdata <= err_q; // RULE_12
                `LTD_OFF_INT_STATUS: reg_rdata <= {29'h00000000, ist_q};
                `LTD_OFF_INT_ENABLE: reg_rdata <= {29'h00000000, ien_q};
                `LTD_OFF_SRC_CLASS:  reg_rdata <= class_q;
                default:             reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_io_event;
        dio_err_rsp;
    endsequence

    a_io_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_io_event |=> err_q[31]) else $error("io error flag not set"); // RULE_01
    a_msg_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        txu_err_rsp |=> err_q[30]) else $error("message error flag not set"); // RULE_02
    a_fmt_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        rxu_fmt_err |=> err_q[28]) else $error("format flag not set"); // RULE_03
    a_ill_resp_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        (dio_ill_rsp || txu_ill_rsp) |=> err_q[27]) else $error("illegal decode not set"); // RULE_04
    a_ill_req_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mau_ill_req || rxu_ill_req) |=> err_q[27]) else $error("illegal decode not set"); // RULE_05
    a_req_tmo_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        rxu_req_tmo |=> err_q[25]) else $error("request timeout not set"); // RULE_06
    a_rsp_tmo_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        (dio_rsp_tmo || txu_rsp_tmo) |=> err_q[24]) else $error("response timeout not set"); // RULE_07
    a_unsol_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        (dio_unsol_rsp || txu_unsol_rsp) |=> err_q[23]) else $error("unsolicited not set"); // RULE_08
    a_unsup_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        mau_unsup |=> err_q[22]) else $error("unsupported not set"); // RULE_09
    a_rxq_sec_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        rxu_queue_block |=> err_q[7]) else $error("queue security not set"); // RULE_10
    a_dma_blk_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        mau_dma_block |=> err_q[6]) else $error("dma access flag not set"); // RULE_11
    a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        (err_q & ~`LTD_FLAG_MASK) == 32'h00000000) else $error("reserved bit set"); // RULE_12
    a_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        (err_q[31] && !(wr_err && !reg_wdata[31])) |=> err_q[31]) else $error("flag lost"); // RULE_13
    a_write_one_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr_err && (reg_wdata == 32'hFFFFFFFF)) |=> (err_q == ($past(err_q) | $past(set_w)))) else $error("write one changed flag"); // RULE_17
    a_clear_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr_err && (reg_wdata == 32'h00000000) && (set_w == 32'h00000000)) |=> (err_q == 32'h00000000)) else $error("clear failed"); // RULE_13
    a_err_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ist_q[0] && ien_q[0]) |=> irq_error) else $error("error irq missing"); // RULE_14
    a_crit_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
        critical_event && ien_q[1] && !wr_ien ##1 1'b1 |=> irq_critical) else $error("critical irq missing"); // RULE_15
    a_serv_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ien_q[2] |=> !irq_service) else $error("service irq not gated"); // RULE_16

    ////////////////////////////////////////////////////////////////////////////
    // word-level checks; one clock domain, so they share a default clock and reset
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_read_err;
        reg_rd && (reg_addr == `LTD_OFF_ERR_DETECT);
    endsequence

    sequence s_io_raised;
        dio_err_rsp ##1 err_q[31];
    endsequence

    sequence s_err_status;
        (|(set_w & ~class_q)) ##1 (ist_q[0] && ien_q[0]);
    endsequence

    sequence s_crit_status;
        (|(set_w & class_q)) ##1 (ist_q[1] && ien_q[1]);
    endsequence

    sequence s_serv_status;
        service_event ##1 (ist_q[2] && ien_q[2]);
    endsequence

    // reset must win over every other update, so this one is never disabled
    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_n |=> (err_q == 32'h00000000) && (ist_q == 3'h0) && (ien_q == 3'h0) && (class_q == 32'h00000000)
        && (reg_rdata == 32'h00000000) && !irq_error && !irq_critical && !irq_service) else $error("reset state wrong");

    // error word update
    a_err_write_word: assert property ( // RULE_13 RULE_17
        (wr_err && (set_w == 32'h00000000)) |=> (err_q == ($past(err_q) & $past(reg_wdata) & `LTD_FLAG_MASK)))
        else $error("error word write wrong");
    a_err_hold_idle: assert property ( // RULE_13
        (!wr_err && (set_w == 32'h00000000)) |=> $stable(err_q))
        else $error("error word moved");
    a_err_set_wins: assert property ( // RULE_13
        (wr_err && (set_w != 32'h00000000)) |=> ((err_q & $past(set_w)) == $past(set_w)))
        else $error("clear beat a new event");
    a_err_or_set: assert property ( // RULE_13
        !wr_err |=> (err_q == ($past(err_q) | $past(set_w))))
        else $error("error word gained wrong bits");
    a_err_no_spur: assert property ( // RULE_13
        (set_w == 32'h00000000) |=> ((err_q & ~$past(err_q)) == 32'h00000000))
        else $error("flag set with no event");
    a_wr_reserved: assert property ( // RULE_12
        wr_err |=> ((err_q & ~`LTD_FLAG_MASK) == 32'h00000000))
        else $error("reserved bit written");
    a_io_clear_seq: assert property ( // RULE_13
        s_io_raised ##0 (wr_err && !reg_wdata[31] && !dio_err_rsp) |=> !err_q[31])
        else $error("io flag not cleared");
    a_keep_b30: assert property ( // RULE_13
        (err_q[30] && !(wr_err && !reg_wdata[30])) |=> err_q[30])
        else $error("message flag lost");
    a_keep_b7: assert property ( // RULE_13
        (err_q[7] && !(wr_err && !reg_wdata[7])) |=> err_q[7])
        else $error("queue flag lost");
    a_keep_b6: assert property ( // RULE_13
        (err_q[6] && !(wr_err && !reg_wdata[6])) |=> err_q[6])
        else $error("dma flag lost");

    // read port
    a_rd_err_data: assert property ( // RULE_12
        s_read_err |=> (reg_rdata == $past(err_q)))
        else $error("error word read wrong");
    a_rd_err_masked: assert property ( // RULE_12
        s_read_err |=> ((reg_rdata & ~`LTD_FLAG_MASK) == 32'h00000000))
        else $error("reserved bit read");
    a_rd_status: assert property (
        (reg_rd && (reg_addr == `LTD_OFF_INT_STATUS)) |=> (reg_rdata == {29'h00000000, $past(ist_q)}))
        else $error("status read wrong");
    a_rd_enable: assert property (
        (reg_rd && (reg_addr == `LTD_OFF_INT_ENABLE)) |=> (reg_rdata == {29'h00000000, $past(ien_q)}))
        else $error("enable read wrong");
    a_rd_class: assert property (
        (reg_rd && (reg_addr == `LTD_OFF_SRC_CLASS)) |=> (reg_rdata == $past(class_q)))
        else $error("class read wrong");
    a_rd_clear_zero: assert property (
        (reg_rd && (reg_addr == `LTD_OFF_INT_CLEAR)) |=> (reg_rdata == 32'h00000000))
        else $error("clear register read not zero");
    a_rd_idle_zero: assert property (
        !reg_rd |=> (reg_rdata == 32'h00000000))
        else $error("read data outside its cycle");

    // configuration registers
    a_ien_write: assert property (
        wr_ien |=> (ien_q == $past(reg_wdata[2:0])))
        else $error("enable write wrong");
    a_ien_hold: assert property (
        !wr_ien |=> $stable(ien_q))
        else $error("enable moved");
    a_cls_write: assert property ( // RULE_15
        wr_cls |=> (class_q == ($past(reg_wdata) & `LTD_FLAG_MASK)))
        else $error("class write wrong");
    a_cls_hold: assert property (
        !wr_cls |=> $stable(class_q))
        else $error("class moved");
    a_unmapped_wr: assert property (
        (reg_wr && !wr_err && !wr_ien && !wr_icl && !wr_cls) |=> ($stable(ien_q) && $stable(class_q)))
        else $error("unmapped write took effect");

    // interrupt status
    a_ist_sets: assert property ( // RULE_14 RULE_15 RULE_16
        (iset_w != 3'h0) |=> ((ist_q & $past(iset_w)) == $past(iset_w)))
        else $error("status bit not set");
    a_ist_clear: assert property (
        (wr_icl && (iset_w == 3'h0)) |=> (ist_q == ($past(ist_q) & ~$past(reg_wdata[2:0]))))
        else $error("status clear wrong");
    a_ist_hold: assert property (
        (!wr_icl && (iset_w == 3'h0)) |=> $stable(ist_q))
        else $error("status moved");
    a_ist_no_spur: assert property ( // RULE_14
        (iset_w == 3'h0) |=> ((ist_q & ~$past(ist_q)) == 3'h0))
        else $error("status set with no event");
    a_err_route: assert property ( // RULE_14
        (|(set_w & ~class_q)) |=> ist_q[0])
        else $error("error status not raised");
    a_crit_route: assert property ( // RULE_15
        (|(set_w & class_q)) |=> ist_q[1])
        else $error("classed flag not critical");
    a_crit_event: assert property ( // RULE_15
        critical_event |=> ist_q[1])
        else $error("critical status not raised");
    a_serv_event: assert property ( // RULE_16
        service_event |=> ist_q[2])
        else $error("service status not raised");
    a_serv_separate: assert property ( // RULE_16
        (service_event && (iset_w[1:0] == 2'h0) && !wr_icl) |=> (ist_q[1:0] == $past(ist_q[1:0])))
        else $error("service touched error status");
    a_flag_clr_keeps: assert property ( // RULE_14
        (wr_err && ist_q[0]) |=> ist_q[0])
        else $error("flag clear dropped status");

    // interrupt outputs
    a_err_irq_low: assert property ( // RULE_14
        !(ist_q[0] && ien_q[0]) |=> !irq_error)
        else $error("error irq without cause");
    a_crit_irq_low: assert property ( // RULE_15
        !(ist_q[1] && ien_q[1]) |=> !irq_critical)
        else $error("critical irq without cause");
    a_serv_irq_low: assert property ( // RULE_16
        !(ist_q[2] && ien_q[2]) |=> !irq_service)
        else $error("service irq without cause");
    a_crit_irq_high: assert property ( // RULE_15
        (ist_q[1] && ien_q[1]) |=> irq_critical)
        else $error("critical irq missing");
    a_serv_irq_high: assert property ( // RULE_16
        (ist_q[2] && ien_q[2]) |=> irq_service)
        else $error("service irq missing");
    a_err_gate: assert property ( // RULE_14
        !ien_q[0] |=> !irq_error)
        else $error("error irq not gated");
    a_crit_gate: assert property ( // RULE_15
        !ien_q[1] |=> !irq_critical)
        else $error("critical irq not gated");

    // event to interrupt chains, two register stages long
    a_err_chain: assert property ( // RULE_14
        s_err_status |=> irq_error)
        else $error("error chain broken");
    a_crit_chain: assert property ( // RULE_15
        s_crit_status |=> irq_critical)
        else $error("critical chain broken");
    a_serv_chain: assert property ( // RULE_16
        s_serv_status |=> irq_service)
        else $error("service chain broken");
endmodule
`default_nettype wire

// ===== verification/ltd_event_src.sv
// event source model for the request, transmit, receive and memory access units
`timescale 1ns/10ps
`default_nettype none
module ltd_event_src (
    // clock
    input  wire logic        core_clk,
    // one command bit per event line
    input  wire logic [16:0] fire,
    // event lines, registered like the real units, so glitch-free and never combinational paths
    output var  logic [16:0] evt
);
    logic [16:0] evt_q = 17'h00000;
    always_ff @(posedge core_clk) begin
        evt_q <= fire;
    end
    assign evt = evt_q;
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the error detect register and its interrupts
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import ltd_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    ltd_addr_t reg_addr = 8'h00;
    ltd_word_t reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    ltd_word_t reg_rdata;
    ltd_word_t d;
    logic [16:0] fire = 17'h00000;
    logic [16:0] evt;
    logic irq_error, irq_critical, irq_service;
    int n_errors = 0;
    int tests_run = 0;
    int pos [15] = '{31, 30, 28, 27, 27, 27, 27, 25, 24, 24, 23, 23, 22, 7, 6};
    always #5 core_clk = ~core_clk;
    ltd_event_src ltd_event_src_i (.core_clk(core_clk), .fire(fire), .evt(evt));
    ltd_error_detect ltd_error_detect_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .dio_err_rsp(evt[0]), .txu_err_rsp(evt[1]), .rxu_fmt_err(evt[2]), .dio_ill_rsp(evt[3]),
        .txu_ill_rsp(evt[4]), .mau_ill_req(evt[5]), .rxu_ill_req(evt[6]), .rxu_req_tmo(evt[7]),
        .dio_rsp_tmo(evt[8]), .txu_rsp_tmo(evt[9]), .dio_unsol_rsp(evt[10]), .txu_unsol_rsp(evt[11]),
        .mau_unsup(evt[12]), .rxu_queue_block(evt[13]), .mau_dma_block(evt[14]),
        .critical_event(evt[15]), .service_event(evt[16]), .irq_error(irq_error),
        .irq_critical(irq_critical), .irq_service(irq_service));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input ltd_word_t seen, input ltd_word_t exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input ltd_addr_t a, input ltd_word_t w);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input ltd_addr_t a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // event c0 reaches status c1 and the irq output c2; the model adds one register stage
    task automatic pulse(input int i);
        @(posedge core_clk);
        fire <= 17'h00001 << i;
        @(posedge core_clk);
        fire <= 17'h00000;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge core_clk);
        n_errors++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 15; i++) begin
            pulse(i);
            rd(8'h00);
            chk(d, 32'h00000001 << pos[i]);
            wr(8'h00, 32'hFFFFFFFF);
            rd(8'h00);
            chk(d, 32'h00000001 << pos[i]);
            wr(8'h00, 32'h00000000);
            rd(8'h00);
            chk(d, 32'h00000000);
            wr(8'h0C, 32'h00000007);
        end
        // reset and the awkward cases: all flags at once, interrupts, unmapped place
        for (int i = 0; i < 15; i++) fire[i] <= 1'b1;
        @(posedge core_clk);
        fire <= 17'h00000;
        repeat (3) @(posedge core_clk);
        rd(8'h00);
        chk(d, 32'hDBC000C0);
        wr(8'h00, 32'h7FFFFFFF);
        rd(8'h00);
        chk(d, 32'h5BC000C0);
        rd(8'h20);
        chk(d, 32'h00000000);
        wr(8'h0C, 32'h00000007);
        wr(8'h08, 32'h00000007);
        pulse(0);
        chk({29'h0, irq_service, irq_critical, irq_error}, 32'h00000001);
        wr(8'h08, 32'h00000000);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq_error}, 32'h00000000);
        wr(8'h0C, 32'h00000001);
        rd(8'h04);
        chk(d, 32'h00000000);
        wr(8'h08, 32'h00000007);
        pulse(15);
        chk({29'h0, irq_service, irq_critical, irq_error}, 32'h00000002);
        pulse(16);
        chk({29'h0, irq_service, irq_critical, irq_error}, 32'h00000006);
        wr(8'h10, 32'h80000000);
        rd(8'h10);
        chk(d, 32'h80000000);
        wr(8'h0C, 32'h00000007);
        pulse(0);
        chk({29'h0, irq_service, irq_critical, irq_error}, 32'h00000002);
        rd(8'h04);
        chk(d, 32'h00000002);
        @(posedge core_clk);
        #1 chk(reg_rdata, 32'h00000000);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(8'h00);
        chk(d, 32'h00000000);
        rd(8'h08);
        chk(d, 32'h00000000);
        chk({29'h0, irq_service, irq_critical, irq_error}, 32'h00000000);
        close_out();
    end
endmodule
`default_nettype wire
